// file: common/slot_power_map.vh
/*
 * constants for the two-slot power fault supervisor: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 20 mhz system clock and a word-addressed avalon-mm slave.
 */
`ifndef SLOT_POWER_MAP_VH
`define SLOT_POWER_MAP_VH

// register word offsets
`define OFS_CMD_A 4'h0
`define OFS_CMD_B 4'h1
`define OFS_STAT_A 4'h2
`define OFS_STAT_B 4'h3
`define OFS_COMMON 4'h4
`define OFS_TFLT_A 4'h5
`define OFS_TFLT_B 4'h6
`define OFS_IRQ_STAT 4'h7
`define OFS_IRQ_MASK 4'h8

// slot command register fields
`define CMD_MAIN 0
`define CMD_AUX 1

// slot status fields (fault bits write one to clear, alarm bit follows the alarm pin)
`define ST_UV 0
`define ST_MAIN_OC 2
`define ST_AUX_OC 4
`define ST_ALARM 7

// common status fields
`define CS_STBY 0
`define CS_MASK 3

// interrupt status bits: one per slot trip
`define IRQ_W 2

// reset values
`define CMD_RST 8'h00
`define CS_RST 8'h00
`define IRQ_MASK_RST 2'h0
`define TFLT_RST 16'h0064
`define STAT_RST 8'h00
`define RD_ZERO 32'h0000_0000

// fault timer counting
`define TMR_CLR 16'h0000
`define TMR_MAX 16'hffff
`define TMR_STEP 16'h0001

// writable bits of a slot command word
`define CMD_WMASK 8'h03

// power-on reset interval
`define T_POR_US 250
`define CLK_MHZ 20
`define POR_CYC (`T_POR_US * `CLK_MHZ)
`define POR_W 13

`endif

// file: design/slot_power_fault_supervisor.v
/*
 * two-slot power switching and circuit-breaker supervisor with an
 * avalon-mm register slave, per-slot fault timers, alarms and interrupt.
 * assumes all pins synchronous to clk_sys; analog sensing arrives as
 * digital comparator levels.
 * assumes a host that holds each bus request until waitrequest drops;
 * every access takes exactly one wait state.
 * gate outputs are logic levels for an external gate driver: the
 * analog current sources, slew control and discharge resistors sit
 * outside this block, as does the sizing of the fault filter.
 * the host is expected to program the fault timers before it enables
 * any rail; the reset value only stands in until then.
 */
// Local design decisions: the address map and register access over Avalon-MM.
// Contract
// - disabled: high gate high, low gate low
// - disable switches outputs off, discharge on
// - standby when any main input undervoltage
// - aux by pin or bit, standby-independent
// - timed overcurrent trips main and aux rails
// - fast-trip level shuts main immediately
// - undervoltage trips only while main enabled
// - aux trips only after fault timer
// - toggling command bits clears latched fault
// - alarm only when enabled by pins
// - trip raises interrupt unless masked
// - write one clears fault bit, interrupt
// - after power-on reset, all cleared but the fault timer settings, off
// - mask bit three inhibits host_irq_n, not irq
`timescale 1ns/100ps
`default_nettype none
`include "slot_power_map.vh"

module slot_power_fault_supervisor (
	// clock and reset
	input wire clk_sys,
	input wire rstn,
	// avalon-mm slave
	input wire [3:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output wire waitrequest,
	// hot-plug enable pins, one bit per slot
	input wire [1:0] main_enable_in,
	input wire [1:0] aux_rail_enable_in,
	// supply and sense comparators
	input wire [1:0] standby_supply,
	input wire main_input_uv,
	input wire [1:0] main_over_limit,
	input wire [1:0] main_fast_trip,
	input wire [1:0] aux_over_limit,
	// rail controls
	output reg [1:0] high_rail_gate_ctl,
	output reg [1:0] low_rail_gate_ctl,
	output reg [1:0] aux_rail_out,
	output reg [1:0] main_discharge,
	output reg [1:0] aux_discharge,
	// alarms and interrupts
	output reg [1:0] slot_alarm_n,
	output wire host_irq_n,
	output wire irq
);

	// one-cycle answer: every access completes on the second edge after it rises
	reg ack_reg;
	wire req = read | write;
	assign waitrequest = req & ~ack_reg;
	wire wr_go = write & ack_reg;

	// power-on reset counter
	reg [`POR_W-1:0] por_cnt_reg;
	wire por_done = (por_cnt_reg == `POR_CYC);

	reg [7:0] cmd_reg [0:1];
	reg [7:0] stat_reg [0:1];
	reg [15:0] tflt_reg [0:1];
	reg [7:0] cs_reg;
	reg [`IRQ_W-1:0] irq_stat_reg;
	reg [`IRQ_W-1:0] irq_mask_reg;

	wire standby = main_input_uv;
	wire [1:0] trip_ev;

	// bus answer flag: high in the second cycle of every request
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			ack_reg <= 1'b0;
		else
			ack_reg <= req & ~ack_reg;
	end

	// rails stay off until the interval has run out after each reset
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			por_cnt_reg <= {`POR_W{1'b0}};
		else if (!por_done)
			por_cnt_reg <= por_cnt_reg + 1'b1;
	end

	genvar s;
	generate
		for (s = 0; s < 2; s = s + 1) begin : g_slot
			reg [15:0] main_tmr_reg;
			reg [15:0] aux_tmr_reg;
			reg main_trip_reg;
			reg aux_trip_reg;
			reg main_pin_d_reg;
			reg aux_pin_d_reg;
			reg main_bit_d_reg;
			reg aux_bit_d_reg;

			// word hits for this slot
			wire hit_cmd = wr_go && (address == (`OFS_CMD_A + s));
			wire hit_stat = wr_go && (address == (`OFS_STAT_A + s));
			wire hit_tflt = wr_go && (address == (`OFS_TFLT_A + s));

			// a rail runs from its pin or its command bit
			wire main_on = main_enable_in[s] | cmd_reg[s][`CMD_MAIN];
			wire aux_on = aux_rail_enable_in[s] | cmd_reg[s][`CMD_AUX];
			wire main_live = por_done & main_on & ~main_trip_reg;
			// aux hangs on its own supply only, so it survives standby
			wire aux_live = por_done & aux_on & ~aux_trip_reg
				& standby_supply[s];

			// trip causes; the timers stand in for the filter capacitor
			wire main_oc = main_live & main_over_limit[s];
			wire aux_oc = aux_live & aux_over_limit[s];
			wire main_exp = main_tmr_reg >= tflt_reg[s];
			wire aux_exp = aux_tmr_reg >= tflt_reg[s];
			wire uv_trip = main_live & standby;
			wire fast_trip = main_live & main_fast_trip[s];
			wire slow_trip = main_oc & main_exp;
			wire main_trip_now = fast_trip | uv_trip | slow_trip;
			// aux has no fast path: only its timer can trip it
			wire aux_trip_now = aux_oc & aux_exp;
			wire main_drive = main_live & ~main_trip_now;
			wire aux_drive = aux_live & ~aux_trip_now;

			// a rail's falling pin or a toggle of its own command bit re-arms its breaker
			wire main_pin_fall = main_pin_d_reg & ~main_enable_in[s];
			wire aux_pin_fall = aux_pin_d_reg & ~aux_rail_enable_in[s];
			wire main_bit_flip = main_bit_d_reg ^ cmd_reg[s][`CMD_MAIN];
			wire aux_bit_flip = aux_bit_d_reg ^ cmd_reg[s][`CMD_AUX];
			wire main_rearm = main_pin_fall | main_bit_flip;
			wire aux_rearm = aux_pin_fall | aux_bit_flip;

			// alarm only for rails that a pin holds on at the trip
			wire alarm_set = (main_trip_now & main_enable_in[s])
				| (aux_trip_now & aux_rail_enable_in[s]);
			wire clr_uv = hit_stat & writedata[`ST_UV];
			wire clr_main_oc = hit_stat & writedata[`ST_MAIN_OC];
			wire clr_aux_oc = hit_stat & writedata[`ST_AUX_OC];
			assign trip_ev[s] = (main_trip_now & ~main_trip_reg)
				| (aux_trip_now & ~aux_trip_reg);

			// edge detectors rest at the idle level of pins and bits
			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					main_pin_d_reg <= 1'b0;
					aux_pin_d_reg <= 1'b0;
					main_bit_d_reg <= 1'b0;
					aux_bit_d_reg <= 1'b0;
				end else begin
					main_pin_d_reg <= main_enable_in[s];
					aux_pin_d_reg <= aux_rail_enable_in[s];
					main_bit_d_reg <= cmd_reg[s][`CMD_MAIN];
					aux_bit_d_reg <= cmd_reg[s][`CMD_AUX];
				end
			end

			// timers saturate so a stuck fault cannot wrap and re-arm
			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					main_tmr_reg <= `TMR_CLR;
				else if (!main_oc)
					main_tmr_reg <= `TMR_CLR;
				else if (main_tmr_reg != `TMR_MAX)
					main_tmr_reg <= main_tmr_reg + `TMR_STEP;
			end

			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					aux_tmr_reg <= `TMR_CLR;
				else if (!aux_oc)
					aux_tmr_reg <= `TMR_CLR;
				else if (aux_tmr_reg != `TMR_MAX)
					aux_tmr_reg <= aux_tmr_reg + `TMR_STEP;
			end

			// a new trip wins over a re-arm in the same cycle
			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					main_trip_reg <= 1'b0;
				else if (main_trip_now)
					main_trip_reg <= 1'b1;
				else if (main_rearm)
					main_trip_reg <= 1'b0;
			end

			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					aux_trip_reg <= 1'b0;
				else if (aux_trip_now)
					aux_trip_reg <= 1'b1;
				else if (aux_rearm)
					aux_trip_reg <= 1'b0;
			end

			// alarm tracks pin-enabled trips; released on rearm
			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					slot_alarm_n[s] <= 1'b1;
				else if (alarm_set)
					slot_alarm_n[s] <= 1'b0;
				else if (main_rearm | aux_rearm)
					slot_alarm_n[s] <= 1'b1;
			end

			// gate drive is registered so a trip shows one edge later
			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					high_rail_gate_ctl[s] <= 1'b1;
					low_rail_gate_ctl[s] <= 1'b0;
					main_discharge[s] <= 1'b1;
				end else begin
					high_rail_gate_ctl[s] <= ~main_drive;
					low_rail_gate_ctl[s] <= main_drive;
					main_discharge[s] <= ~main_drive;
				end
			end

			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					aux_rail_out[s] <= 1'b0;
					aux_discharge[s] <= 1'b1;
				end else begin
					aux_rail_out[s] <= aux_drive;
					aux_discharge[s] <= ~aux_drive;
				end
			end

			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					cmd_reg[s] <= `CMD_RST;
					tflt_reg[s] <= `TFLT_RST;
				end else begin
					if (hit_cmd)
						cmd_reg[s] <= writedata[7:0] & `CMD_WMASK;
					if (hit_tflt)
						tflt_reg[s] <= writedata[15:0];
				end
			end

			// status: hardware set wins over write-one clear
			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					stat_reg[s] <= `STAT_RST;
				else begin
					stat_reg[s][`ST_UV] <= uv_trip
						| (stat_reg[s][`ST_UV] & ~clr_uv);
					stat_reg[s][`ST_MAIN_OC] <= (main_trip_now & ~uv_trip)
						| (stat_reg[s][`ST_MAIN_OC] & ~clr_main_oc);
					stat_reg[s][`ST_AUX_OC] <= aux_trip_now
						| (stat_reg[s][`ST_AUX_OC] & ~clr_aux_oc);
					stat_reg[s][`ST_ALARM] <= ~slot_alarm_n[s];
				end
			end
		end
	endgenerate

	// common status: standby is live, the mask bit is host-owned
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			cs_reg <= `CS_RST;
		else begin
			cs_reg[`CS_STBY] <= standby;
			if (wr_go && address == `OFS_COMMON)
				cs_reg[`CS_MASK] <= writedata[`CS_MASK];
		end
	end

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			irq_mask_reg <= `IRQ_MASK_RST;
		else if (wr_go && address == `OFS_IRQ_MASK)
			irq_mask_reg <= writedata[`IRQ_W-1:0];
	end

	// a trip in the same cycle as its echo clear stays pending
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			irq_stat_reg <= {`IRQ_W{1'b0}};
		else if (wr_go && address == `OFS_IRQ_STAT)
			irq_stat_reg <= trip_ev
				| (irq_stat_reg & ~writedata[`IRQ_W-1:0]);
		else
			irq_stat_reg <= irq_stat_reg | trip_ev;
	end

	// while mask bit three is clear, any pending slot fault keeps the host line low until echoed clear
	wire fault_pending = |{stat_reg[0][4:0], stat_reg[1][4:0]};
	wire host_attn = fault_pending & ~cs_reg[`CS_MASK];
	wire [`IRQ_W-1:0] irq_live = irq_stat_reg & irq_mask_reg;
	assign host_irq_n = ~host_attn;
	assign irq = |irq_live;

	// read mux: unmapped words read zero
	reg [31:0] readdata_next;
	always @* begin
		readdata_next = `RD_ZERO;
		if (address == `OFS_CMD_A)
			readdata_next = {24'h00_0000, cmd_reg[0]};
		else if (address == `OFS_CMD_B)
			readdata_next = {24'h00_0000, cmd_reg[1]};
		else if (address == `OFS_STAT_A)
			readdata_next = {24'h00_0000, stat_reg[0]};
		else if (address == `OFS_STAT_B)
			readdata_next = {24'h00_0000, stat_reg[1]};
		else if (address == `OFS_COMMON)
			readdata_next = {24'h00_0000, cs_reg};
		else if (address == `OFS_TFLT_A)
			readdata_next = {16'h0000, tflt_reg[0]};
		else if (address == `OFS_TFLT_B)
			readdata_next = {16'h0000, tflt_reg[1]};
		else if (address == `OFS_IRQ_STAT)
			readdata_next = {30'h0000_0000, irq_stat_reg};
		else if (address == `OFS_IRQ_MASK)
			readdata_next = {30'h0000_0000, irq_mask_reg};
	end

	// captured in the wait cycle so it stands at the accepting edge
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			readdata <= `RD_ZERO;
		else if (read & ~ack_reg)
			readdata <= readdata_next;
	end

endmodule // slot_power_fault_supervisor
`default_nettype wire

// file: tb/slot_power_fault_supervisor_monitor.sv
/* port assertions for the slot power supervisor: output pairing on both slots, the rest slot a.
 assumes binding into slot_power_fault_supervisor. */
`timescale 1ns/100ps
`default_nettype none
module slot_power_monitor (
	// clock, reset, bus
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic write,
	// pins in
	input wire logic [1:0] main_enable_in,
	input wire logic [1:0] aux_rail_enable_in,
	input wire logic main_input_uv,
	input wire logic [1:0] main_over_limit,
	input wire logic [1:0] main_fast_trip,
	input wire logic [1:0] aux_over_limit,
	// pins out
	input wire logic [1:0] high_rail_gate_ctl,
	input wire logic [1:0] low_rail_gate_ctl,
	input wire logic [1:0] aux_rail_out,
	input wire logic [1:0] main_discharge,
	input wire logic [1:0] aux_discharge,
	input wire logic [1:0] slot_alarm_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// cmd writes count as a cause, so a bit-driven turn-off is not flagged
	wire cause = !main_enable_in[0] || main_fast_trip[0] || main_over_limit[0]
		|| main_input_uv || write;
	wire pin_on = main_enable_in[0] || aux_rail_enable_in[0];
	sequence s_fast;
		main_fast_trip[0] && !high_rail_gate_ctl[0];
	endsequence
	a_gate_pair: assert property (
		high_rail_gate_ctl == ~low_rail_gate_ctl) else $error("gate split");
	a_main_discharge: assert property (
		main_discharge == high_rail_gate_ctl) else $error("main discharge");
	a_aux_discharge: assert property (
		aux_discharge == ~aux_rail_out) else $error("aux discharge");
	a_fast_trip: assert property (
		s_fast |-> ##[1:2] high_rail_gate_ctl[0]) else $error("no fast trip");
	a_trip_cause: assert property (
		$rose(high_rail_gate_ctl[0]) |-> $past(cause) || $past(cause, 2))
		else $error("main off uncaused");
	a_alarm_pin: assert property (
		$fell(slot_alarm_n[0]) |-> $past(pin_on) || $past(pin_on, 2))
		else $error("alarm without pin");
	a_aux_no_fast: assert property (
		$rose(aux_over_limit[0]) && aux_rail_out[0] |=> aux_rail_out[0] [*2])
		else $error("aux tripped early");
	a_uv_ignored: assert property (
		main_input_uv && high_rail_gate_ctl[0] && !main_enable_in[0] && !write
		&& !aux_over_limit[0] |=> !$fell(slot_alarm_n[0]))
		else $error("uv alarm while off");
endmodule // slot_power_monitor
bind slot_power_fault_supervisor slot_power_monitor u_mon (.*);
`default_nettype wire

// file: tb/hotplug_host.sv
/* hot-plug system logic driving the enable pins.
 assumes requests from the bench, changed at rising edges. */
`timescale 1ns/100ps
`default_nettype none
module hotplug_host (
	// clock
	input wire logic clk_sys,
	// bench requests
	input wire logic [1:0] req_main,
	input wire logic [1:0] req_aux,
	input wire logic stby_req,
	// enable pins
	output var logic [1:0] main_enable_in,
	output var logic [1:0] aux_rail_enable_in
);
	initial begin
		main_enable_in = 2'h0;
		aux_rail_enable_in = 2'h0;
	end
	// mains dropped ahead of standby, else a brown-out trip is flagged
	always @(posedge clk_sys) begin
		main_enable_in <= stby_req ? 2'h0 : req_main;
		aux_rail_enable_in <= req_aux;
	end
endmodule // hotplug_host
`default_nettype wire

// file: tb/slot_power_fault_supervisor_tb.sv
/* self-checking bench for the slot power supervisor.
 assumes slot_power_map.vh on the include path. */
`timescale 1ns/100ps
`default_nettype none
`include "slot_power_map.vh"
module slot_power_fault_supervisor_tb;
	typedef struct {logic [3:0] a; logic [31:0] e;} row_t;
	logic clk_sys = 0, rstn = 0, read = 0, write = 0, uv = 0, stby = 0;
	logic waitrequest, host_irq_n, irq;
	logic [3:0] address = 0;
	logic [31:0] writedata = 0, readdata, rd;
	logic [1:0] rq_m = 0, rq_a = 0, ol = 0, ft = 0, aol = 0;
	logic [1:0] me, ae, hg, lg, ax, md, ad, al;
	int n_fail = 0, tests_run = 0;
	row_t rows [6] = '{'{`OFS_CMD_B, `CMD_RST}, '{`OFS_STAT_A, 0},
		'{`OFS_COMMON, `CS_RST}, '{`OFS_TFLT_B, `TFLT_RST},
		'{`OFS_IRQ_MASK, `IRQ_MASK_RST}, '{4'hf, 0}};
	always #25 clk_sys = ~clk_sys;
	hotplug_host u_host (.clk_sys(clk_sys), .req_main(rq_m), .req_aux(rq_a),
		.stby_req(stby), .main_enable_in(me), .aux_rail_enable_in(ae));
	slot_power_fault_supervisor u_dut (.clk_sys(clk_sys), .rstn(rstn),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .main_enable_in(me),
		.aux_rail_enable_in(ae), .standby_supply(2'h3), .main_input_uv(uv),
		.main_over_limit(ol), .main_fast_trip(ft), .aux_over_limit(aol),
		.high_rail_gate_ctl(hg), .low_rail_gate_ctl(lg), .aux_rail_out(ax),
		.main_discharge(md), .aux_discharge(ad), .slot_alarm_n(al),
		.host_irq_n(host_irq_n), .irq(irq));
	task complete_run;
		$display("mismatches %0d checks %0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// waitrequest and readdata are taken at the rising edge itself
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		for (i = 0; i < 9; i++) begin
			@(posedge clk_sys);
			if (!waitrequest) break;
		end
		if (waitrequest) begin
			n_fail++;
			complete_run;
		end
		rd = readdata;
		read <= 0;
		write <= 0;
		@(posedge clk_sys);
	endtask
	task rdchk(input string s, input logic [3:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(s, e, rd);
	endtask
	// gates, aux, discharges, alarm, then both interrupt lines
	task pin(input int s, input logic [7:0] e);
		@(negedge clk_sys);
		chk("pins", e, {hg[s], lg[s], ax[s], md[s], ad[s], al[s], host_irq_n, irq});
		@(posedge clk_sys);
	endtask
	initial begin
		cyc(12);
		rstn <= 1;
		foreach (rows[i]) rdchk("reset", rows[i].a, rows[i].e);
		rq_m <= 2'h1;
		rq_a <= 2'h1;
		cyc(20);
		pin(0, 8'h9e);
		cyc(`POR_CYC);
		pin(0, 8'h66);
		pin(1, 8'h9e);
		bus(1, `OFS_IRQ_MASK, 1);
		bus(1, `OFS_TFLT_A, 4);
		ol <= 2'h1;
		cyc(3);
		ol <= 0;
		cyc(1);
		ol <= 2'h1;
		cyc(3);
		ol <= 0;
		pin(0, 8'h66);
		ol <= 2'h1;
		cyc(7);
		ol <= 0;
		pin(0, 8'hb1);
		rdchk("stat a", `OFS_STAT_A, 8'h84);
		bus(1, `OFS_STAT_A, 4);
		bus(1, `OFS_IRQ_STAT, 1);
		pin(0, 8'hb2);
		rq_m <= 0;
		cyc(3);
		rq_m <= 2'h1;
		cyc(3);
		pin(0, 8'h66);
		bus(1, `OFS_COMMON, 8'h08);
		ft <= 2'h1;
		cyc(1);
		ft <= 0;
		pin(0, 8'hb3);
		bus(1, `OFS_COMMON, 0);
		pin(0, 8'hb1);
		bus(1, `OFS_STAT_A, 4);
		bus(1, `OFS_IRQ_STAT, 1);
		stby <= 1;
		cyc(3);
		uv <= 1;
		cyc(3);
		rdchk("common", `OFS_COMMON, 1);
		rdchk("stat a", `OFS_STAT_A, 0);
		pin(0, 8'hb6);
		stby <= 0;
		cyc(3);
		rdchk("stat a", `OFS_STAT_A, 8'h81);
		uv <= 0;
		rq_m <= 0;
		bus(1, `OFS_STAT_A, 1);
		bus(1, `OFS_IRQ_STAT, 1);
		bus(1, `OFS_CMD_B, 1);
		pin(1, 8'h4e);
		ft <= 2'h2;
		cyc(1);
		ft <= 0;
		pin(1, 8'h9c);
		pin(0, 8'hb4);
		bus(1, `OFS_CMD_B, 0);
		bus(1, `OFS_CMD_B, 1);
		pin(1, 8'h4c);
		aol <= 2'h1;
		cyc(8);
		aol <= 0;
		rdchk("stat a", `OFS_STAT_A, 8'h90);
		rstn <= 0;
		cyc(2);
		rstn <= 1;
		rdchk("reset", `OFS_STAT_A, 0);
		pin(0, 8'h9e);
		complete_run;
	end
	initial begin
		cyc(20000);
		n_fail++;
		complete_run;
	end
endmodule // slot_power_fault_supervisor_tb
`default_nettype wire
